// [dlr_mode_regs.sv]
// Latency, io-mode and repair mode registers with auto-precharge timing
// Notes on behaviour
// (R1) Read latency column follows read inversion enable
// (R2) Write latency set follows set select bit
// (R3) Controller keeps clock inside code's frequency band
// (R4) Write auto-precharge waits write recovery cycles
// (R5) Read auto-precharge waits read-to-precharge cycles
// (R6) 32-beat reads add eight clocks
// (R7) Controller matches calibration point on both channels
// (R8) Postamble bit selects half or one-and-half clock
// (R9) Protection bit sticky until power-on reset
// (R10) Protection blocks writing repair entry to one
// (R11) Write updates only write set-point copy
// (R12) Device operates from operating set-point copy
// (R13) Repair entry bit enters and exits repair
// (R14) Reset loads default encodings into all fields
`timescale 1ns/1ps
module dlr_mode_regs
  import dlr_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire dlr_mrw_t    mrw_in,
  input  wire logic        wr_ap_done_in,
  input  wire logic        rd_ap_done_in,
  input  wire logic        burst32_in,
  output logic [5:0]       read_latency_cycles_out,
  output logic [5:0]       write_latency_cycles_out,
  output logic [5:0]       write_recovery_cycles_out,
  output logic [5:0]       read_to_precharge_cycles_out,
  output dlr_io_cfg_t      io_cfg_out,
  output logic             postamble_long_out,
  output logic             repair_mode_out,
  output logic             precharge_start_out
);
  logic [7:0]    io_cfg [2];
  logic [7:0]    latency [2];
  logic [7:0]    next_io_cfg [2];
  logic [7:0]    next_latency [2];
  logic          write_set_point_select;
  logic          operating_set_point_select;
  logic          next_wsp;
  logic          next_osp;
  logic          repair;
  logic          next_repair;
  logic          protect_any;
  logic [7:0]    act_io;
  logic [7:0]    act_lat;
  logic [2:0]    rl_code;
  logic [2:0]    wl_code;
  dlr_pc_state_t pc_state;
  dlr_pc_state_t next_pc_state;
  logic [5:0]    pc_count;
  logic [5:0]    next_pc_count;

  // Write targets the copy picked by the write set point
  function automatic logic hits(input logic sel, input int idx);
    return sel == idx[0];
  endfunction

  assign protect_any = io_cfg[0][POS_PROT] | io_cfg[1][POS_PROT];

  // Register update decisions
  always_comb begin
    next_wsp     = write_set_point_select;
    next_osp     = operating_set_point_select;
    next_repair  = repair;
    next_io_cfg  = io_cfg;
    next_latency = latency;
    if (mrw_in.valid) begin
      for (int i = 0; i < 2; i++) begin
        if (hits(write_set_point_select, i)) begin // R11
          if (mrw_in.addr == ADDR_IO_CFG) begin
            next_io_cfg[i] = mrw_in.data;
            next_io_cfg[i][POS_PROT] = io_cfg[i][POS_PROT] | mrw_in.data[POS_PROT]; // R9
          end
          if (mrw_in.addr == ADDR_LATENCY) begin
            next_latency[i] = mrw_in.data;
          end
        end
      end
      if (mrw_in.addr == ADDR_SETPT) begin
        next_wsp = mrw_in.data[POS_FSPWR];
        next_osp = mrw_in.data[POS_FSPOP];
      end
      if (mrw_in.addr == ADDR_THERMAL) begin
        if (!mrw_in.data[POS_REPAIR_ENTRY_BIT]) begin
          next_repair = 1'b0; // R13
        end else if (!protect_any) begin // R10
          next_repair = 1'b1; // R13
        end
      end
    end
  end

  // Register storage, reset to defaults
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      io_cfg[0]  <= IO_CFG_RESET; // R14
      io_cfg[1]  <= IO_CFG_RESET; // R14
      latency[0] <= LATENCY_RESET;
      latency[1] <= LATENCY_RESET;
      write_set_point_select     <= 1'b0;
      operating_set_point_select <= 1'b0;
      repair <= 1'b0;
    end else begin
      io_cfg  <= next_io_cfg;
      latency <= next_latency;
      write_set_point_select     <= next_wsp;
      operating_set_point_select <= next_osp;
      repair <= next_repair;
    end
  end

  // Active copy selection
  assign act_io  = io_cfg[operating_set_point_select]; // R12
  assign act_lat = latency[operating_set_point_select]; // R12
  assign rl_code = act_lat[2:0];
  assign wl_code = act_lat[5:3];

  // Latency lookups, registered outputs
  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      read_latency_cycles_out      <= RL_NODBI[0];
      write_latency_cycles_out     <= WL_SET_A[0];
      write_recovery_cycles_out    <= WR_CYC[0];
      read_to_precharge_cycles_out <= RTP_CYC[0];
      io_cfg_out         <= dlr_io_cfg_t'(IO_CFG_RESET);
      postamble_long_out <= 1'b0;
      repair_mode_out    <= 1'b0;
    end else begin
      read_latency_cycles_out <= act_io[POS_RDBI] ? RL_DBI[rl_code] : RL_NODBI[rl_code]; // R1
      write_latency_cycles_out <= act_lat[POS_WLS] ? WL_SET_B[wl_code] : WL_SET_A[wl_code]; // R2
      write_recovery_cycles_out    <= WR_CYC[rl_code];
      read_to_precharge_cycles_out <= RTP_CYC[rl_code];
      io_cfg_out         <= dlr_io_cfg_t'(act_io);
      postamble_long_out <= act_io[POS_WPST]; // R8
      repair_mode_out    <= repair;
    end
  end

  // Auto-precharge countdown
  always_comb begin
    next_pc_state = pc_state;
    next_pc_count = pc_count;
    unique case (pc_state)
      PC_IDLE: begin
        if (wr_ap_done_in) begin
          next_pc_count = write_recovery_cycles_out; // R4
          next_pc_state = PC_COUNT;
        end else if (rd_ap_done_in) begin
          next_pc_count = burst32_in ? read_to_precharge_cycles_out + BL32_RTP_ADD // R6
                                     : read_to_precharge_cycles_out; // R5
          next_pc_state = PC_COUNT;
        end
      end
      PC_COUNT: begin
        next_pc_count = pc_count - 6'h01;
        if (pc_count == 6'h01) begin
          next_pc_state = PC_FIRE;
        end
      end
      PC_FIRE: begin
        next_pc_state = PC_IDLE;
      end
      default: next_pc_state = PC_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      pc_state <= PC_IDLE;
      pc_count <= 6'h00;
    end else begin
      pc_state <= next_pc_state;
      pc_count <= next_pc_count;
    end
  end

  assign precharge_start_out = (pc_state == PC_FIRE);

  // Checks
  chk_prot_sticky: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R9
    $past(io_cfg[0][POS_PROT]) |-> io_cfg[0][POS_PROT])
    else $error("protection bit cleared");
  chk_prot_blocks: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R10
    (protect_any && !repair) |=> !repair)
    else $error("repair entered while protected");
  chk_repair_exit: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R13
    (mrw_in.valid && mrw_in.addr == ADDR_THERMAL && !mrw_in.data[POS_REPAIR_ENTRY_BIT]) |=> !repair)
    else $error("repair not exited");
  chk_inactive_kept: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R11
    (mrw_in.valid && mrw_in.addr == ADDR_IO_CFG && !write_set_point_select)
      |=> io_cfg[1] == $past(io_cfg[1]))
    else $error("inactive copy written");
  chk_rd_dbi: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R1
    act_io[POS_RDBI] |=> read_latency_cycles_out == RL_DBI[$past(rl_code)])
    else $error("read latency column wrong");
  chk_wl_set: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R2
    !act_lat[POS_WLS] |=> write_latency_cycles_out == WL_SET_A[$past(wl_code)])
    else $error("write latency set wrong");
  chk_postamble: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R8
    ##1 postamble_long_out == $past(io_cfg[operating_set_point_select][POS_WPST]))
    else $error("postamble select wrong");
  chk_wr_ap: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    (pc_state == PC_IDLE && wr_ap_done_in && write_recovery_cycles_out == 6'h06)
      |=> (pc_state == PC_COUNT) [*6] ##1 precharge_start_out)
    else $error("write recovery timing wrong");
  chk_rd_ap32: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R6
    (pc_state == PC_IDLE && !wr_ap_done_in && rd_ap_done_in && burst32_in)
      |=> pc_count == $past(read_to_precharge_cycles_out) + BL32_RTP_ADD)
    else $error("burst32 extra clocks missing");
  chk_wr_load: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4
    (pc_state == PC_IDLE && wr_ap_done_in) |=> pc_count == $past(write_recovery_cycles_out))
    else $error("write recovery count not loaded");
  chk_rd_load: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R5
    (pc_state == PC_IDLE && !wr_ap_done_in && rd_ap_done_in && !burst32_in)
      |=> pc_count == $past(read_to_precharge_cycles_out))
    else $error("read to precharge count not loaded");
  chk_pc_pulse: assert property (@(posedge clk_in) disable iff (!rst_n_in) // R4 R5
    precharge_start_out |=> !precharge_start_out)
    else $error("precharge start held too long");
  cov_repair: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(repair));
  cov_prot: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(protect_any));
  cov_pc: cover property (@(posedge clk_in) disable iff (!rst_n_in) precharge_start_out);
  cov_osp: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(operating_set_point_select));
endmodule // dlr_mode_regs

// [dlr_pkg.sv]
// Package for the latency and io-mode register block
package dlr_pkg;
  // Mode register addresses
  localparam logic [5:0] ADDR_LATENCY = 6'h02;
  localparam logic [5:0] ADDR_IO_CFG  = 6'h03;
  localparam logic [5:0] ADDR_THERMAL = 6'h04;
  localparam logic [5:0] ADDR_SETPT   = 6'h0D;
  // Field positions
  localparam int POS_PUCAL = 0;
  localparam int POS_WPST  = 1;
  localparam int POS_PROT  = 2;
  localparam int POS_PULLDOWN_DRIVE_STRENGTH  = 3;
  localparam int POS_RDBI  = 6;
  localparam int POS_WDBI  = 7;
  localparam int POS_WLS   = 6;
  localparam int POS_REPAIR_ENTRY_BIT  = 4;
  localparam int POS_FSPWR = 6;
  localparam int POS_FSPOP = 7;
  // Reset values
  localparam logic [7:0] IO_CFG_RESET  = 8'h31;
  localparam logic [7:0] LATENCY_RESET = 8'h00;
  // Extra clocks for 32-beat read bursts
  localparam logic [5:0] BL32_RTP_ADD = 6'h08;
  // Latency code tables, index by three-bit code
  localparam logic [5:0] RL_NODBI [8] = '{6'h06, 6'h0A, 6'h0E, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h24};
  localparam logic [5:0] RL_DBI   [8] = '{6'h06, 6'h0C, 6'h10, 6'h16, 6'h1C, 6'h20, 6'h24, 6'h28};
  localparam logic [5:0] WL_SET_A [8] = '{6'h04, 6'h06, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10, 6'h12};
  localparam logic [5:0] WL_SET_B [8] = '{6'h04, 6'h08, 6'h0C, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22};
  localparam logic [5:0] WR_CYC   [8] = '{6'h06, 6'h0A, 6'h10, 6'h14, 6'h18, 6'h1E, 6'h22, 6'h28};
  localparam logic [5:0] RTP_CYC  [8] = '{6'h08, 6'h08, 6'h08, 6'h08, 6'h0A, 6'h0C, 6'h0E, 6'h10};
  // Mode register write command
  typedef struct packed {
    logic       valid;
    logic [5:0] addr;
    logic [7:0] data;
  } dlr_mrw_t;
  // Decoded io configuration
  typedef struct packed {
    logic       write_inversion_enable;
    logic       read_inversion_enable;
    logic [2:0] pulldown_drive_strength;
    logic       repair_protection_bit;
    logic       write_postamble_length;
    logic       pullup_calibration_point;
  } dlr_io_cfg_t;
  // Precharge countdown states
  typedef enum logic [1:0] {
    PC_IDLE  = 2'b00,
    PC_COUNT = 2'b01,
    PC_FIRE  = 2'b10
  } dlr_pc_state_t;
endpackage

// [dlr_ctrl_model.sv]
// Memory controller model issuing mode register writes and burst ends
`timescale 1ns/1ps
module dlr_ctrl_model
  import dlr_pkg::*;
(
  input  wire logic clk_in,
  output dlr_mrw_t  mrw_out,
  output logic      wr_ap_out,
  output logic      rd_ap_out,
  output logic      burst32_out
);
  // Idle command bus from time zero
  initial begin
    mrw_out     = '{valid: 1'b0, addr: 6'h3F, data: 8'hFF};
    wr_ap_out   = 1'b0;
    rd_ap_out   = 1'b0;
    burst32_out = 1'b0;
  end
  // One write held over its taking edge; released bus shows the inverse
  task automatic mode_register_write_command(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 mrw_out = '{valid: 1'b1, addr: a, data: d};
    @(posedge clk_in);
    #1 mrw_out = '{valid: 1'b0, addr: ~a, data: ~d};
  endtask
  // One end-of-burst pulse with auto-precharge
  task automatic burst_end(input logic wr, input logic b32);
    @(posedge clk_in);
    #1 wr_ap_out = wr;
    rd_ap_out   = ~wr;
    burst32_out = b32;
    @(posedge clk_in);
    #1 wr_ap_out = 1'b0;
    rd_ap_out   = 1'b0;
    burst32_out = 1'b0;
  endtask
endmodule // dlr_ctrl_model

// [tb_dram_latency_and_io_mode_regs.sv]
// Self-checking bench for the latency and io-mode registers
`timescale 1ns/1ps
module tb_dram_latency_and_io_mode_regs
  import dlr_pkg::*;
;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  dlr_mrw_t    mode_register_write_command;
  logic        wr_ap, rd_ap, b32;
  logic [5:0]  rl, wl, wr, rtp;
  dlr_io_cfg_t io;
  logic        pst, rep, pcs;
  int          mismatches = 0;
  int          n_tests = 0;
  // 20 MHz command clock, inside the lowest band
  always #25 clk_in = ~clk_in;
  dlr_ctrl_model i_ctrl (.clk_in(clk_in), .mrw_out(mode_register_write_command), .wr_ap_out(wr_ap),
    .rd_ap_out(rd_ap), .burst32_out(b32));
  dlr_mode_regs i_dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .mrw_in(mode_register_write_command),
    .wr_ap_done_in(wr_ap), .rd_ap_done_in(rd_ap), .burst32_in(b32),
    .read_latency_cycles_out(rl), .write_latency_cycles_out(wl),
    .write_recovery_cycles_out(wr), .read_to_precharge_cycles_out(rtp),
    .io_cfg_out(io), .postamble_long_out(pst), .repair_mode_out(rep),
    .precharge_start_out(pcs));
  // Compare and count
  task automatic chk(input string nm, input logic [7:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wrt(input logic [5:0] a, input logic [7:0] d);
    i_ctrl.mode_register_write_command(a, d);
    settle(2);
  endtask
  // Burst end, then pulse launched n edges after the taking edge, one cycle wide
  task automatic pre(input logic w, input logic b, input int n);
    i_ctrl.burst_end(w, b);
    settle(n - 1);
    chk("early precharge", 8'(pcs), 8'h00);
    settle(1);
    chk("precharge", 8'(pcs), 8'h01);
    settle(1);
    chk("precharge end", 8'(pcs), 8'h00);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence; calibration point kept at 1 in every io write
  initial begin
    settle(3);
    rst_n_in = 1'b1;
    chk("io cfg", io, 8'h31);
    chk("read latency", 8'(rl), 8'h06);
    chk("postamble", 8'(pst), 8'h00);
    for (int k = 0; k < 2; k++) begin
      for (int c = 0; c < 8; c++) begin
        wrt(ADDR_IO_CFG, 8'h31 | 8'(k << 6));
        wrt(ADDR_LATENCY, {1'b0, k[0], c[2:0], c[2:0]});
        chk("read latency", 8'(rl), 8'(k ? RL_DBI[c] : RL_NODBI[c]));
        chk("write latency", 8'(wl), 8'(k ? WL_SET_B[c] : WL_SET_A[c]));
        chk("write recovery", 8'(wr), 8'(WR_CYC[c]));
        chk("read to precharge", 8'(rtp), 8'(RTP_CYC[c]));
      end
    end
    pre(1'b1, 1'b0, 40);
    pre(1'b0, 1'b0, 16);
    pre(1'b0, 1'b1, 24);
    wrt(ADDR_IO_CFG, 8'h33);
    chk("postamble long", 8'(pst), 8'h01);
    wrt(ADDR_IO_CFG, 8'h31);
    chk("postamble short", 8'(pst), 8'h00);
    wrt(ADDR_SETPT, 8'h40);
    wrt(ADDR_IO_CFG, 8'hF1);
    chk("inactive copy", io, 8'h31);
    wrt(ADDR_SETPT, 8'hC0);
    chk("active copy one", io, 8'hF1);
    wrt(ADDR_SETPT, 8'h00);
    chk("active copy zero", io, 8'h31);
    wrt(6'h05, 8'hFF);
    chk("unmapped", io, 8'h31);
    wrt(ADDR_THERMAL, 8'h10);
    chk("repair entry", 8'(rep), 8'h01);
    wrt(ADDR_THERMAL, 8'h00);
    chk("repair exit", 8'(rep), 8'h00);
    wrt(ADDR_IO_CFG, 8'h35);
    wrt(ADDR_IO_CFG, 8'h31);
    chk("protection sticky", io, 8'h35);
    wrt(ADDR_THERMAL, 8'h10);
    chk("entry refused", 8'(rep), 8'h00);
    rst_n_in = 1'b0;
    settle(3);
    rst_n_in = 1'b1;
    chk("io after reset", io, 8'h31);
    chk("recovery after reset", 8'(wr), 8'h06);
    wrt(ADDR_THERMAL, 8'h10);
    chk("entry after reset", 8'(rep), 8'h01);
    pre(1'b1, 1'b0, 6);
    give_verdict();
  end
  // Watchdog, far beyond the expected run length
  initial begin
    #2000000;
    mismatches++;
    give_verdict();
  end
endmodule // tb_dram_latency_and_io_mode_regs
